/* rtl/qsg_top.sv */
// What this block does
// (R1) Condition register shows live questionable conditions, 1 active, 0 inactive.
// (R2) Event register is read-only, holds events, clears to zero when read.
// (R3) Only condition bits 13 and 12 can set event bits.
// (R4) Mode error bits 0 and 1 are never latched, live only.
// (R5) Bits 0 and 1 may both be set, meaning output settling.
// (R6) Bit 14 means absorbing energy; bit 3 means thermal error.
// (R7) Bit 13 current error, bit 12 voltage error; enabled ones latch.
// (R8) Enable register masks event capture and summary contribution per bit.
// (R9) Summary output, status byte bit 3, is OR of enabled events.
// (R10) Enable register reads back the mask last written.
// (R11) Status preset loads the enable mask with 255 cut to the used bits, so it reads 004B.
// (R12) Unused bits read zero in all registers and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module qsg_top
    import qsg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire qsg_pkg::qsg_cond_type cond_in,
    input wire qsg_pkg::qsg_req_type req,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic questionable_summary
);
    import qsg_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] qsg_used(input logic [15:0] v);
        qsg_used = v & QSG_USED_MASK;
    endfunction

    // Same selector test serves reads and writes
    function automatic logic qsg_hit(input logic [1:0] sel, input logic [1:0] want);
        qsg_hit = (sel == want);
    endfunction

    // Edge, not level: a standing condition latches once, so a read empties the register
    function automatic logic [15:0] qsg_rise(input logic [15:0] cur, input logic [15:0] prev);
        qsg_rise = cur & ~prev;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] cond_word;
    logic [15:0] cond_prev_reg;
    logic [15:0] capture;
    logic [15:0] event_reg;
    logic [15:0] event_next;
    logic [15:0] enab_reg;
    logic [15:0] enab_next;
    logic [15:0] read_word;
    logic read_take;
    logic event_read;
    logic enab_write;
    logic summary_next;
    qsg_state_type state_reg;
    qsg_state_type state_next;

    // ------------------------------------------------------------
    // Live conditions
    // ------------------------------------------------------------
    // Pins are asynchronous to core_clk
    qsg_cond_sync u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cond_async(cond_in),
        .cond_word(cond_word) // R1 R5 R6
    );

    // ------------------------------------------------------------
    // Rising-edge detect
    // ------------------------------------------------------------
    // Cleared to the idle level of the pins, so reset gives no false edge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cond_prev_reg <= 16'h0000;
        end else begin
            cond_prev_reg <= cond_word;
        end
    end

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    // Bits 0 and 1 excluded by the latch mask
    assign capture = qsg_rise(cond_word, cond_prev_reg) & enab_reg & QSG_LATCH_MASK; // R3 R4 R7 R8

    // ------------------------------------------------------------
    // Event register
    // ------------------------------------------------------------
    // Only an answered read clears; a refused read loses nothing
    assign event_read = read_take && qsg_hit(req.sel, QSG_SEL_EVENT); // R2

    // New capture wins over the read clear, so no event is lost
    always_comb begin
        event_next = event_reg;
        if (event_read) begin
            event_next = QSG_RESET_EVENT; // R2
        end
        event_next = event_next | capture;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            event_reg <= QSG_RESET_EVENT;
        end else begin
            event_reg <= event_next; // R2
        end
    end

    // ------------------------------------------------------------
    // Enable mask
    // ------------------------------------------------------------
    assign enab_write = req.wr && qsg_hit(req.sel, QSG_SEL_ENAB);

    // Preset beats a write in the same cycle
    always_comb begin
        enab_next = enab_reg;
        if (req.preset) begin
            enab_next = qsg_used(QSG_PRESET_ENAB); // R11 R12
        end else if (enab_write) begin
            enab_next = qsg_used(req.wdata); // R10 R12
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            enab_reg <= QSG_RESET_ENAB;
        end else begin
            enab_reg <= enab_next; // R10
        end
    end

    // ------------------------------------------------------------
    // Read handshake
    // ------------------------------------------------------------
    // A read in the answer cycle is refused, so reads come every second cycle
    assign read_take = req.rd && (state_reg == QSG_IDLE);

    // Gray coded: one bit moves per step
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            QSG_IDLE: begin
                if (req.rd) begin
                    state_next = QSG_ANSWER;
                end
            end
            QSG_ANSWER: begin
                state_next = QSG_IDLE;
            end
            default: begin
                state_next = QSG_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= QSG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        case (req.sel)
            QSG_SEL_EVENT: begin
                read_word = qsg_used(event_reg); // R2 R12
            end
            QSG_SEL_COND: begin
                read_word = qsg_used(cond_word); // R1 R4
            end
            QSG_SEL_ENAB: begin
                read_word = qsg_used(enab_reg); // R10
            end
            default: begin
                read_word = 16'h0000; // R12
            end
        endcase
    end

    // Held until the next taken read
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else if (read_take) begin
            rdata <= read_word;
        end
    end

    // ------------------------------------------------------------
    // Answer strobe
    // ------------------------------------------------------------
    // Exactly one cycle, never twice in a row
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= read_take;
        end
    end

    // ------------------------------------------------------------
    // Summary
    // ------------------------------------------------------------
    // Built from the next event value so summary and event register move together
    assign summary_next = |(event_next & enab_reg); // R8 R9

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            questionable_summary <= 1'b0;
        end else begin
            questionable_summary <= summary_next; // R9
        end
    end
endmodule
`default_nettype wire

/* rtl/qsg_pkg.sv */
package qsg_pkg;

    // ------------------------------------------------------------
    // Register selectors
    // ------------------------------------------------------------
    localparam logic [1:0] QSG_SEL_EVENT = 2'h0;
    localparam logic [1:0] QSG_SEL_COND = 2'h1;
    localparam logic [1:0] QSG_SEL_ENAB = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int QSG_BIT_VOLT_MODE = 0;
    localparam int QSG_BIT_CURR_MODE = 1;
    localparam int QSG_BIT_THERMAL = 3;
    localparam int QSG_BIT_FOLLOWER = 6;
    localparam int QSG_BIT_VOLT_ERR = 12;
    localparam int QSG_BIT_CURR_ERR = 13;
    localparam int QSG_BIT_ABSORB = 14;
    localparam int QSG_STB_SUMMARY_BIT = 3;

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] QSG_USED_MASK = 16'h704B;
    localparam logic [15:0] QSG_LATCH_MASK = 16'h3000;
    localparam logic [15:0] QSG_PRESET_ENAB = 16'h00FF;
    localparam logic [15:0] QSG_RESET_ENAB = 16'h0000;
    localparam logic [15:0] QSG_RESET_EVENT = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic absorbing_energy_flag;
        logic current_error_flag;
        logic voltage_error_flag;
        logic follower_unit_error_flag;
        logic thermal_error_flag;
        logic current_mode_error_flag;
        logic voltage_mode_error_flag;
    } qsg_cond_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic preset;
        logic [1:0] sel;
        logic [15:0] wdata;
    } qsg_req_type;

    typedef enum logic [1:0] {
        QSG_IDLE = 2'h0,
        QSG_ANSWER = 2'h1
    } qsg_state_type;

endpackage

/* rtl/qsg_cond_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module qsg_cond_sync
    import qsg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire qsg_pkg::qsg_cond_type cond_async,
    output logic [15:0] cond_word
);
    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    qsg_cond_type stage1_reg;
    qsg_cond_type stage2_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= cond_async;
            stage2_reg <= stage1_reg;
        end
    end

    // Unused positions tied low
    always_comb begin
        cond_word = 16'h0000;
        cond_word[QSG_BIT_VOLT_MODE] = stage2_reg.voltage_mode_error_flag;
        cond_word[QSG_BIT_CURR_MODE] = stage2_reg.current_mode_error_flag;
        cond_word[QSG_BIT_THERMAL] = stage2_reg.thermal_error_flag;
        cond_word[QSG_BIT_FOLLOWER] = stage2_reg.follower_unit_error_flag;
        cond_word[QSG_BIT_VOLT_ERR] = stage2_reg.voltage_error_flag;
        cond_word[QSG_BIT_CURR_ERR] = stage2_reg.current_error_flag;
        cond_word[QSG_BIT_ABSORB] = stage2_reg.absorbing_energy_flag;
    end
endmodule
`default_nettype wire

/* testbench/qsg_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module qsg_assertions
    import qsg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire qsg_pkg::qsg_cond_type cond_in,
    input wire qsg_pkg::qsg_req_type req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic questionable_summary
);
    // --------------------------------
    // Port checks
    // --------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic req_any = req.rd | req.wr | req.preset;
    read_answer_a: assert property (req.rd && !rvalid |=> rvalid) else $error("read not answered");
    answer_cause_a: assert property (rvalid |-> $past(req.rd)) else $error("answer without read");
    single_pulse_a: assert property (rvalid |=> !rvalid) else $error("answer too long");
    rdata_hold_a: assert property (!rvalid |-> $stable(rdata)) else $error("read data moved");
    unused_zero_a: assert property (rvalid |-> (rdata & ~QSG_USED_MASK) == 16'h0000) else $error("unused set");
    event_latch_a: assert property (rvalid && $past(req.sel) == QSG_SEL_EVENT
        |-> (rdata & ~QSG_LATCH_MASK) == 16'h0000) else $error("event bit outside latch set");
    spare_sel_a: assert property (rvalid && $past(req.sel) == 2'h3 |-> rdata == 16'h0000) else $error("spare read");
    // Summary only drops after a read, write or preset
    summary_fall_a: assert property ($fell(questionable_summary)
        |-> $past(req_any) || $past(req_any, 2) || $past(req_any, 3)) else $error("summary dropped");
    cover property (rvalid && rdata[13]);
    cover property ($fell(questionable_summary));
    cover property (rvalid && rdata == 16'h004B);
endmodule
bind qsg_top qsg_assertions u_qsg_assertions (.core_clk(core_clk), .rst_b(rst_b), .cond_in(cond_in), .req(req),
    .rdata(rdata), .rvalid(rvalid), .questionable_summary(questionable_summary));
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import qsg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    qsg_cond_type cond_in = '0;
    qsg_req_type req = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic questionable_summary;
    int err_count = 0;
    int tests_run = 0;
    qsg_top u_qsg_top (.core_clk(core_clk), .rst_b(rst_b), .cond_in(cond_in), .req(req), .rdata(rdata),
        .rvalid(rvalid), .questionable_summary(questionable_summary));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // --------------------------------
    // Access tasks
    // --------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Kind bits: read, write, preset
    task automatic op(input logic [2:0] k, input logic [1:0] s, input logic [15:0] d);
        @(posedge core_clk);
        #5 req = '{rd: k[2], wr: k[1], preset: k[0], sel: s, wdata: d};
        @(posedge core_clk);
        #5 req = '0;
    endtask
    // Answer is exactly one cycle late, so no wait loop
    task automatic rd(input logic [1:0] s, input logic [15:0] exp);
        op(3'h4, s, 16'h0000);
        chk("rvalid", 16'h0001, {15'h0000, rvalid});
        chk("rdata", exp, rdata);
    endtask
    // Synchroniser plus capture needs a few cycles
    task automatic idle;
        repeat (5) @(posedge core_clk);
        #5;
    endtask
    task automatic cnd(input logic [6:0] c);
        @(posedge core_clk);
        #5 cond_in = c;
        idle();
    endtask
    task automatic sum(input logic e);
        chk("summary", {15'h0000, e}, {15'h0000, questionable_summary});
    endtask
    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        #5 rst_b = 1'b1;
        rd(QSG_SEL_ENAB, QSG_RESET_ENAB);
        rd(QSG_SEL_EVENT, QSG_RESET_EVENT);
        op(3'h2, QSG_SEL_ENAB, 16'hFFFF);
        rd(QSG_SEL_ENAB, 16'h704B);
        op(3'h3, QSG_SEL_ENAB, 16'h3000);
        rd(QSG_SEL_ENAB, 16'h004B);
        rd(2'h3, 16'h0000);
        op(3'h2, QSG_SEL_EVENT, 16'hFFFF);
        rd(QSG_SEL_EVENT, 16'h0000);
        op(3'h2, QSG_SEL_ENAB, 16'h3000);
        cnd(7'h7F);
        rd(QSG_SEL_COND, 16'h704B);
        sum(1'b1);
        rd(QSG_SEL_EVENT, 16'h3000);
        cnd(7'h00);
        rd(QSG_SEL_COND, 16'h0000);
        rd(QSG_SEL_EVENT, 16'h0000);
        rd(QSG_SEL_EVENT, 16'h0000);
        idle();
        sum(1'b0);
        op(3'h2, QSG_SEL_ENAB, 16'hFFFF);
        cnd(7'h47);
        rd(QSG_SEL_COND, 16'h400B);
        rd(QSG_SEL_EVENT, 16'h0000);
        op(3'h2, QSG_SEL_ENAB, 16'h0000);
        cnd(7'h20);
        rd(QSG_SEL_EVENT, 16'h0000);
        sum(1'b0);
        op(3'h2, QSG_SEL_ENAB, 16'h2000);
        cnd(7'h00);
        cnd(7'h20);
        sum(1'b1);
        op(3'h2, QSG_SEL_ENAB, 16'h0000);
        cnd(7'h00);
        sum(1'b0);
        rd(QSG_SEL_EVENT, 16'h2000);
        give_verdict();
    end
endmodule
`default_nettype wire
